// ==== rtl/dac_defines.svh ====
// Field positions, reset values and code constants for the DAC programming block.
`ifndef DAC_DEFINES_SVH
`define DAC_DEFINES_SVH

// ----------------------------------------------------------------------------
// Sizes
// ----------------------------------------------------------------------------
`define NUM_CHANNELS 8
`define SER_LAST_BIT 4'hF

// ----------------------------------------------------------------------------
// System control register
// ----------------------------------------------------------------------------
`define SYS_CTRL_RST 8'h60
`define SYS_CODING_BIT 6
`define SYS_PD_BIT 5
`define SYS_REF_HI_BIT 3
`define SYS_REF_LO_BIT 2
`define PD_ACTIVE_RST 1'b0

// ----------------------------------------------------------------------------
// Channel control register
// ----------------------------------------------------------------------------
`define CH_CTRL_RST 8'h00
`define CH_SUB_SEL_BIT 0
`define CH_STBY_BIT 1
`define CH_EXT_REF_BIT 4

// ----------------------------------------------------------------------------
// Write decode
// ----------------------------------------------------------------------------
`define PAR_CHAN_SEL_BIT 9
`define SER_SUB_BIT 15
`define SER_SEL_HI 14
`define SER_SEL_LO 13
`define SER_CH_HI 12
`define SER_CH_LO 10
`define SER_SYS_OB_WORD 16'h0060
`define SER_CH_EXT_WORD 16'h4210
`define SER_MAIN_FS_WORD 16'h23FF
`define SER_SUB_FS_WORD 16'hA3FF
`define PAR_SYS_TC_WORD 10'h020

// ----------------------------------------------------------------------------
// Code interpretation
// ----------------------------------------------------------------------------
`define MAIN_TC_FLIP 10'h200
`define SUB_TC_FLIP 8'h7F
`define MAIN_FULL 10'h3FF
`define SUB_FULL 8'hFF
`define MAIN_MID 15'sh0200
`define SUB_MID 15'sh0080
`define MAIN_GAIN 15'sh000F
`define SUB_GAIN 15'sh0002

`endif

// ==== rtl/dac_pkg.sv ====
// Types shared by the DAC programming block and its channel slices.
package dac_pkg;

  typedef enum logic [1:0] {
    SEL_SYS  = 2'b00,
    SEL_DATA = 2'b01,
    SEL_CHAN = 2'b10,
    SEL_RSVD = 2'b11
  } reg_sel_t;

  typedef struct packed {
    logic sys;
    logic chan_ctrl;
    logic main;
    logic sub;
    logic [2:0] chan;
    logic [9:0] data;
  } write_req_t;

  typedef struct packed {
    logic [9:0] main_code;
    logic [7:0] sub_code;
    logic signed [13:0] level;
    logic ext_ref;
    logic standby;
  } chan_out_t;

endpackage

// ==== rtl/dac_channel.sv ====
// One converter channel: control, input and converter registers, code mapping.
`timescale 1ns/1ps
`include "dac_defines.svh"

module dac_channel
  import dac_pkg::*;
(
  input wire logic ref_clk,
  input wire logic arst_n,
  input wire logic wr_ctrl,
  input wire logic wr_main,
  input wire logic wr_sub,
  input wire logic [9:0] wr_data,
  input wire logic load,
  input wire logic offset_binary,
  output logic sub_target,
  output chan_out_t chan_out
);

  logic [7:0] ctrl_q;
  logic [9:0] main_in_q;
  logic [9:0] main_in_d;
  logic [7:0] sub_in_q;
  logic [7:0] sub_in_d;
  logic [9:0] main_dac_q;
  logic [7:0] sub_dac_q;
  chan_out_t out_q;
  logic [9:0] main_n;
  logic [7:0] sub_n;
  logic signed [14:0] main_off;
  logic signed [14:0] sub_off;
  logic signed [14:0] level_sum;

  assign sub_target = ctrl_q[`CH_SUB_SEL_BIT];
  assign chan_out = out_q;

  always_ff @(posedge ref_clk or negedge arst_n) begin
    if (!arst_n) begin
      ctrl_q <= `CH_CTRL_RST;
    end else if (wr_ctrl) begin
      ctrl_q <= wr_data[7:0];
    end
  end

  // ----------------------------------------------------------------------------
  // Double buffer
  // ----------------------------------------------------------------------------
  assign main_in_d = wr_main ? wr_data : main_in_q;
  assign sub_in_d = wr_sub ? wr_data[7:0] : sub_in_q;

  always_ff @(posedge ref_clk or negedge arst_n) begin
    if (!arst_n) begin
      main_in_q <= 10'h000;
      sub_in_q <= 8'h00;
    end else begin
      main_in_q <= main_in_d;
      sub_in_q <= sub_in_d;
    end
  end

  // A load in the same cycle as a write takes the new word, so a strobe held
  // low updates the converter with the word just written.
  always_ff @(posedge ref_clk or negedge arst_n) begin
    if (!arst_n) begin
      main_dac_q <= 10'h000;
      sub_dac_q <= 8'h00;
    end else if (load) begin
      main_dac_q <= main_in_d;
      sub_dac_q <= sub_in_d;
    end
  end

  // ----------------------------------------------------------------------------
  // Code mapping
  // ----------------------------------------------------------------------------
  // Codes are turned into straight binary; the level is in units of bias/8192.
  always_comb begin
    main_n = offset_binary ? main_dac_q : (main_dac_q ^ `MAIN_TC_FLIP);
    sub_n = offset_binary ? sub_dac_q : (sub_dac_q ^ `SUB_TC_FLIP);
    main_off = $signed({5'b00000, main_n}) - `MAIN_MID;
    sub_off = $signed({7'b0000000, sub_n}) - `SUB_MID;
    level_sum = (`MAIN_GAIN * main_off) + (`SUB_GAIN * sub_off);
  end

  always_ff @(posedge ref_clk or negedge arst_n) begin
    if (!arst_n) begin
      out_q <= '0;
    end else begin
      out_q.main_code <= main_n;
      out_q.sub_code <= sub_n;
      out_q.level <= level_sum[13:0];
      out_q.ext_ref <= ctrl_q[`CH_EXT_REF_BIT];
      out_q.standby <= ctrl_q[`CH_STBY_BIT];
    end
  end

  // ----------------------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------------------
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (!arst_n);

  sync_load_main_a: assert property (load && wr_main |-> ##2 out_q.main_code ==
      (offset_binary ? $past(wr_data, 2) : ($past(wr_data, 2) ^ `MAIN_TC_FLIP))
      || !$stable(offset_binary))
    else $error("written main code did not reach the output after load");

  tc_main_ends_a: assert property (!offset_binary && main_dac_q == `MAIN_TC_FLIP
      |=> out_q.main_code == 10'h000)
    else $error("twos complement lowest main code not mapped to zero scale");

  tc_sub_ends_a: assert property (!offset_binary && sub_dac_q == 8'h80
      |=> out_q.sub_code == `SUB_FULL)
    else $error("twos complement sub code not mapped to full scale");

  level_sum_a: assert property (out_q.main_code == `MAIN_FULL
      && out_q.sub_code == `SUB_FULL |-> out_q.level == 14'sd7919)
    else $error("channel level is not the sum of main and sub contributions");

  ob_mid_a: assert property (offset_binary && main_dac_q == 10'h200
      && sub_dac_q == 8'h80 |=> out_q.level == 14'sd0)
    else $error("offset binary mid codes do not give bias");

endmodule

// ==== rtl/dac_register_programming.sv ====
// Write port decode, system control and channel array of the multi-channel DAC.
`timescale 1ns/1ps
`include "dac_defines.svh"

// Notes on behaviour
// - Parallel write with mode low and data bit 9 low goes to system control, address ignored; bit 9 high goes to the addressed channel control.
// - Parallel write with mode high is a data write to the addressed channel.
// - Mode-high data goes to main or sub per that channel's last control write.
// - Twos complement: main code 200 hex lowest, 1FF hex highest.
// - Twos complement: sub code 7F hex zero scale, 80 hex full scale.
// - Offset binary main code 0 to 1023, offset proportional to code minus 512.
// - Offset binary sub code 0 to 255, contribution proportional to code minus 128.
// - Channel output is main voltage plus sub voltage.
// - Serial word 0060 hex selects system control: offset binary, normal operation.
// - Serial word 4210 hex sets first channel to external reference.
// - Serial 23FF hex loads main full scale, A3FF hex sub full scale, channel one.
// - Two reference select bits in system control choose the reference source.
// - Power-down bit 0 powers down everything, 1 normal; registers are kept.
// - After reset coding is offset binary until system control is rewritten.
// - Load strobe low at write completion updates the written channel automatically.

module dac_register_programming
  import dac_pkg::*;
(
  input wire logic ref_clk,
  input wire logic arst_n,
  input wire logic par_wr_n,
  input wire logic par_mode,
  input wire logic channel_addr_bit2,
  input wire logic channel_addr_bit1,
  input wire logic channel_addr_bit0,
  input wire logic [9:0] par_data,
  input wire logic ser_clk,
  input wire logic ser_frame_n,
  input wire logic ser_data,
  input wire logic output_load_strobe_n,
  output logic ref_source_select_hi,
  output logic ref_source_select_lo,
  output logic power_down_active,
  output chan_out_t [7:0] chan_out
);

  logic par_wr_prev_q;
  logic ser_clk_prev_q;
  logic load_prev_q;
  logic [14:0] ser_shift_q;
  logic [3:0] ser_cnt_q;
  logic [7:0] sys_ctrl_q;
  logic pd_q;
  logic first_cycle_q;
  logic par_evt;
  logic ser_fall;
  logic ser_evt;
  logic [15:0] ser_word;
  logic [2:0] par_chan;
  reg_sel_t ser_sel;
  write_req_t req;
  logic sync_load;
  logic async_load;
  logic [`NUM_CHANNELS-1:0] sub_target;

  // ----------------------------------------------------------------------------
  // Edge detection on the host strobes
  // ----------------------------------------------------------------------------
  always_ff @(posedge ref_clk or negedge arst_n) begin
    if (!arst_n) begin
      par_wr_prev_q <= 1'b1;
      ser_clk_prev_q <= 1'b1;
      load_prev_q <= 1'b1;
    end else begin
      par_wr_prev_q <= par_wr_n;
      ser_clk_prev_q <= ser_clk;
      load_prev_q <= output_load_strobe_n;
    end
  end

  assign par_evt = !par_wr_prev_q && par_wr_n;
  assign ser_fall = ser_clk_prev_q && !ser_clk && !ser_frame_n;
  assign ser_evt = ser_fall && (ser_cnt_q == `SER_LAST_BIT);
  assign ser_word = {ser_shift_q, ser_data};
  assign par_chan = {channel_addr_bit2, channel_addr_bit1, channel_addr_bit0};
  assign ser_sel = reg_sel_t'(ser_word[`SER_SEL_HI:`SER_SEL_LO]);

  // ----------------------------------------------------------------------------
  // Serial shift register
  // ----------------------------------------------------------------------------
  // Frame high aborts a partial word, so a short frame never lands anywhere.
  always_ff @(posedge ref_clk or negedge arst_n) begin
    if (!arst_n) begin
      ser_shift_q <= 15'h0000;
      ser_cnt_q <= 4'h0;
    end else if (ser_frame_n) begin
      ser_cnt_q <= 4'h0;
    end else if (ser_fall) begin
      ser_shift_q <= ser_word[14:0];
      ser_cnt_q <= ser_cnt_q + 4'h1;
    end
  end

  // ----------------------------------------------------------------------------
  // Write decode
  // ----------------------------------------------------------------------------
  // Only one port is used in a given system; if both complete together the
  // parallel write wins and the serial word is dropped.
  always_comb begin
    req = '0;
    if (par_evt) begin
      req.chan = par_chan;
      req.data = par_data;
      if (!par_mode) begin
        req.chan_ctrl = par_data[`PAR_CHAN_SEL_BIT];
        req.sys = !par_data[`PAR_CHAN_SEL_BIT];
      end else begin
        req.sub = sub_target[par_chan];
        req.main = !sub_target[par_chan];
      end
    end else if (ser_evt) begin
      req.chan = ser_word[`SER_CH_HI:`SER_CH_LO];
      req.data = ser_word[9:0];
      case (ser_sel)
        SEL_SYS: begin
          req.sys = 1'b1;
        end
        SEL_CHAN: begin
          req.chan_ctrl = 1'b1;
        end
        SEL_DATA: begin
          req.sub = ser_word[`SER_SUB_BIT];
          req.main = !ser_word[`SER_SUB_BIT];
        end
        default: begin
          req.sys = 1'b0;
        end
      endcase
    end
  end

  assign sync_load = (req.main || req.sub) && !output_load_strobe_n;
  assign async_load = load_prev_q && !output_load_strobe_n;

  // ----------------------------------------------------------------------------
  // System control
  // ----------------------------------------------------------------------------
  always_ff @(posedge ref_clk or negedge arst_n) begin
    if (!arst_n) begin
      sys_ctrl_q <= `SYS_CTRL_RST;
    end else if (req.sys) begin
      sys_ctrl_q <= req.data[7:0];
    end
  end

  always_ff @(posedge ref_clk or negedge arst_n) begin
    if (!arst_n) begin
      first_cycle_q <= 1'b1;
    end else begin
      first_cycle_q <= 1'b0;
    end
  end

  // Power-down only flags the analog side; every register keeps its content.
  // The flag has its own flop so that the pin is not an inverter output.
  always_ff @(posedge ref_clk or negedge arst_n) begin
    if (!arst_n) begin
      pd_q <= `PD_ACTIVE_RST;
    end else if (req.sys) begin
      pd_q <= !req.data[`SYS_PD_BIT];
    end
  end

  assign power_down_active = pd_q;
  assign ref_source_select_hi = sys_ctrl_q[`SYS_REF_HI_BIT];
  assign ref_source_select_lo = sys_ctrl_q[`SYS_REF_LO_BIT];

  // ----------------------------------------------------------------------------
  // Channel array
  // ----------------------------------------------------------------------------
  for (genvar i = 0; i < `NUM_CHANNELS; i++) begin : g_chan
    dac_channel u_chan (
      .ref_clk(ref_clk),
      .arst_n(arst_n),
      .wr_ctrl(req.chan_ctrl && req.chan == 3'(i)),
      .wr_main(req.main && req.chan == 3'(i)),
      .wr_sub(req.sub && req.chan == 3'(i)),
      .wr_data(req.data),
      .load(async_load || (sync_load && req.chan == 3'(i))),
      .offset_binary(sys_ctrl_q[`SYS_CODING_BIT]),
      .sub_target(sub_target[i]),
      .chan_out(chan_out[i])
    );
  end

  // ----------------------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------------------
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (!arst_n);

  sys_write_take_a: assert property (par_evt && !par_mode && !par_data[`PAR_CHAN_SEL_BIT]
      |=> sys_ctrl_q == $past(par_data[7:0]))
    else $error("mode low parallel write not taken by system control");

  data_not_ctrl_a: assert property (par_evt && par_mode |=> $stable(sys_ctrl_q))
    else $error("mode high parallel write changed system control");

  sub_route_a: assert property (par_evt && par_mode |-> req.sub == sub_target[par_chan]
      && req.main != req.sub)
    else $error("data write not routed by channel control");

  reset_coding_a: assert property (first_cycle_q |-> sys_ctrl_q[`SYS_CODING_BIT])
    else $error("coding is not offset binary after reset");

  ser_sys_word_a: assert property (ser_evt && !par_evt && ser_word == `SER_SYS_OB_WORD
      |=> sys_ctrl_q[`SYS_CODING_BIT] && !power_down_active)
    else $error("serial system word did not set offset binary normal mode");

  ser_ext_ref_a: assert property (ser_evt && !par_evt && ser_word == `SER_CH_EXT_WORD
      |-> ##2 chan_out[0].ext_ref)
    else $error("serial channel word did not select external reference");

  ser_main_fs_a: assert property (ser_evt && !par_evt
      && ser_word == `SER_MAIN_FS_WORD && !output_load_strobe_n
      && sys_ctrl_q[`SYS_CODING_BIT] && !req.sys
      |-> ##2 chan_out[0].main_code == `MAIN_FULL)
    else $error("serial main full scale not loaded to first channel");

  ref_sel_a: assert property (req.sys |=>
      ref_source_select_hi == $past(req.data[`SYS_REF_HI_BIT])
      && ref_source_select_lo == $past(req.data[`SYS_REF_LO_BIT]))
    else $error("reference select outputs do not follow system control");

  pd_flag_a: assert property (req.sys && !req.data[`SYS_PD_BIT] |=> power_down_active
      && ($stable(chan_out[0].main_code) || $past(async_load, 2) || $past(sync_load, 2)))
    else $error("power-down bit not honoured");

  par_tc_cfg_c: cover property (par_evt && !par_mode && par_data == `PAR_SYS_TC_WORD);
  ser_sub_fs_c: cover property (ser_evt && ser_word == `SER_SUB_FS_WORD);
  async_load_c: cover property (async_load && !par_evt && !ser_evt);

endmodule

// ==== testbench/host_model.sv ====
// Host model that drives the parallel and serial write ports of the DAC block.
`timescale 1ns/1ps
module host_model (
  input wire logic ref_clk,
  output logic par_wr_n,
  output logic par_mode,
  output logic [2:0] addr,
  output logic [9:0] par_data,
  output logic ser_clk,
  output logic ser_frame_n,
  output logic ser_data
);
  // --------------------
  // Write cycles
  // --------------------
  initial begin
    par_wr_n = 1'b1;
    par_mode = 1'b0;
    addr = 3'h0;
    par_data = 10'h155;
    ser_clk = 1'b1;
    ser_frame_n = 1'b1;
    ser_data = 1'b0;
  end

  // The strobe is low one clock and high at least one clock before the next write.
  task automatic par_write(input logic mode, input logic [2:0] a, input logic [9:0] d);
    @(negedge ref_clk);
    par_wr_n = 1'b0;
    par_mode = mode;
    addr = a;
    par_data = d;
    @(negedge ref_clk);
    par_wr_n = 1'b1;
    @(negedge ref_clk);
    // A released bus shows the inverse, so a stale value can never look valid.
    par_mode = ~mode;
    addr = ~a;
    par_data = ~d;
  endtask

  // The serial clock stands high outside frames; each phase lasts two clocks.
  task automatic ser_write(input logic [15:0] w);
    ser_part(w, 16);
  endtask

  // A frame cut after n bits; the device must drop the partial word.
  task automatic ser_part(input logic [15:0] w, input int n);
    @(negedge ref_clk);
    ser_frame_n = 1'b0;
    for (int i = 15; i > 15 - n; i--) begin
      ser_clk = 1'b1;
      ser_data = w[i];
      repeat (2) @(negedge ref_clk);
      ser_clk = 1'b0;
      repeat (2) @(negedge ref_clk);
    end
    ser_frame_n = 1'b1;
    ser_clk = 1'b1;
    ser_data = ~w[16 - n];
  endtask
endmodule

// ==== testbench/tb_top.sv ====
// Self-checking bench for the DAC write decode, code mapping and load logic.
`timescale 1ns/1ps
module tb_top
  import dac_pkg::*;
;
  logic ref_clk;
  logic arst_n;
  logic strobe_n;
  logic par_wr_n, par_mode, ser_clk, ser_frame_n, ser_data;
  logic [2:0] addr;
  logic [9:0] par_data;
  logic ref_hi, ref_lo, pd;
  chan_out_t [7:0] chan_out;
  logic [31:0] r;
  int err_total, checked, sys_m, c;
  int cctl[8], min[8], sin[8], mcv[8], scv[8];
  int bv[2][4] = '{'{'h200, 'h7F, 'h1FF, 'h80}, '{'h000, 'h00, 'h3FF, 'hFF}};

  host_model i_host_model (.ref_clk(ref_clk), .par_wr_n(par_wr_n), .par_mode(par_mode),
    .addr(addr), .par_data(par_data), .ser_clk(ser_clk), .ser_frame_n(ser_frame_n),
    .ser_data(ser_data));

  dac_register_programming i_dac_register_programming (.ref_clk(ref_clk), .arst_n(arst_n),
    .par_wr_n(par_wr_n), .par_mode(par_mode), .channel_addr_bit2(addr[2]),
    .channel_addr_bit1(addr[1]), .channel_addr_bit0(addr[0]), .par_data(par_data),
    .ser_clk(ser_clk), .ser_frame_n(ser_frame_n), .ser_data(ser_data),
    .output_load_strobe_n(strobe_n), .ref_source_select_hi(ref_hi),
    .ref_source_select_lo(ref_lo), .power_down_active(pd), .chan_out(chan_out));

  // --------------------
  // Reference model
  // --------------------
  function automatic logic [31:0] lfsr_step(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction

  task automatic conclude();
    if (err_total == 0 && checked > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask

  task automatic check_all();
    chan_out_t e;
    int m, s;
    for (int k = 0; k < 8; k++) begin
      m = sys_m[6] ? mcv[k] : mcv[k] ^ 'h200;
      s = sys_m[6] ? scv[k] : scv[k] ^ 'h7F;
      e.main_code = m[9:0];
      e.sub_code = s[7:0];
      e.level = 14'(15 * (m - 512) + 2 * (s - 128));
      e.ext_ref = cctl[k][4];
      e.standby = cctl[k][1];
      checked++;
      if (chan_out[k] !== e) begin
        $display("CHECK FAILED %0t channel %0d output", $time, k);
        err_total++;
      end
    end
    checked++;
    if ({ref_hi, ref_lo, pd} !== {sys_m[3], sys_m[2], ~sys_m[5]}) begin
      $display("CHECK FAILED %0t system control outputs", $time);
      err_total++;
    end
  endtask

  task automatic ld(input int k);
    mcv[k] = min[k];
    scv[k] = sin[k];
  endtask

  task automatic pw(input int mode, input int a, input int d);
    i_host_model.par_write(mode[0], a[2:0], d[9:0]);
    if (mode[0]) begin
      if (cctl[a][0]) sin[a] = d & 'hFF;
      else min[a] = d & 'h3FF;
      if (!strobe_n) ld(a);
    end else if (d[9]) cctl[a] = d & 'hFF;
    else sys_m = d & 'hFF;
    repeat (2) @(negedge ref_clk);
    check_all();
  endtask

  task automatic sw(input logic [15:0] w);
    int k;
    k = w[12:10];
    i_host_model.ser_write(w);
    case (w[14:13])
      2'b00: sys_m = w[7:0];
      2'b10: cctl[k] = w[7:0];
      2'b01: begin
        if (w[15]) sin[k] = w[7:0];
        else min[k] = w[9:0];
        if (!strobe_n) ld(k);
      end
      default: ;
    endcase
    repeat (2) @(negedge ref_clk);
    check_all();
  endtask

  // --------------------
  // Stimulus
  // --------------------
  initial begin
    ref_clk = 1'b0;
    forever #4 ref_clk = ~ref_clk;
  end

  initial begin
    repeat (50000) @(posedge ref_clk);
    err_total++;
    $display("CHECK FAILED %0t run did not finish", $time);
    conclude();
  end

  initial begin
    arst_n = 1'b0;
    strobe_n = 1'b0;
    err_total = 0;
    checked = 0;
    sys_m = 'h60;
    r = 32'hE004AF97;
    for (int k = 0; k < 8; k++) begin
      cctl[k] = 0;
      min[k] = 0;
      sin[k] = 0;
      ld(k);
    end
    repeat (6) @(negedge ref_clk);
    arst_n = 1'b1;
    repeat (2) @(negedge ref_clk);
    check_all();
    // Boundary codes in both codings; odd entries go to the sub converter.
    for (int p = 0; p < 2; p++) begin
      r = lfsr_step(r);
      pw(0, r[2:0], p ? 'h060 : 'h020);
      for (int k = 0; k < 4; k++) begin
        r = lfsr_step(r);
        c = r[2:0];
        pw(0, c, 'h200 | (r[15:8] & 'h12) | k[0]);
        pw(1, c, bv[p][k]);
      end
    end
    for (int i = 0; i < 40; i++) begin
      r = lfsr_step(r);
      c = r[2:0];
      if (i % 8 == 0) pw(0, c, (r[3] ? 'h60 : 'h20) | (r[31:24] & 'hC));
      pw(0, c, 'h200 | (r[15:8] & 'h13));
      pw(1, c, r[25:16]);
    end
    pw(0, 2, 'h04C);
    pw(0, 6, 'h060);
    sw(16'h0060);
    sw(16'h4210);
    sw(16'h23FF);
    sw(16'hA3FF);
    sw(16'h2200);
    sw(16'hA080);
    sw(16'h6123);
    i_host_model.ser_part(16'h004C, 15);
    repeat (2) @(negedge ref_clk);
    check_all();
    for (int i = 0; i < 6; i++) begin
      r = lfsr_step(r);
      sw({r[0], 2'b01, r[3:1], r[13:4]});
    end
    strobe_n = 1'b1;
    r = lfsr_step(r);
    pw(1, 3, r[9:0]);
    sw({1'b1, 2'b01, 3'h5, r[19:10]});
    strobe_n = 1'b0;
    for (int k = 0; k < 8; k++) begin
      ld(k);
    end
    repeat (2) @(negedge ref_clk);
    check_all();
    conclude();
  end
endmodule
